// ==== timer_pwm_defines.vh ====
// Register indices, bit positions and reset values for the PWM timer with dead time.
`ifndef TIMER_PWM_DEFINES_VH
`define TIMER_PWM_DEFINES_VH
`define IDX_DT_PRESCALE 8'h23
`define IDX_DT_B 8'h24
`define IDX_DT_A 8'h25
`define IDX_PLL 8'h27
`define IDX_DUTY_B 8'h2b
`define IDX_TOP 8'h2d
`define IDX_DUTY_A 8'h2e
`define IDX_COUNT 8'h2f
`define IDX_CONTROL 8'h30
`define IDX_FLAGS 8'h38
`define IDX_INT_EN 8'h39
`define CTRL_PWM_A 0
`define CTRL_PWM_B 1
`define CTRL_ACT_B_LO 2
`define CTRL_ACT_A_LO 4
`define FLAG_OVF 2
`define FLAG_CMP_B 5
`define FLAG_CMP_A 6
`define FLAG_MASK 8'h64
`define INT_GLOBAL 7
`define PLL_FAST 2
`define PLL_ENABLE 1
`define PLL_LOCK 0
`define TOP_RESET 8'hff
`define COUNT_ONE 8'h01
`define HTRANS_NONSEQ 2'h2
`endif

// ==== deadtime_gen.v ====
// Dead-time generator turning one PWM signal into a non-overlapping output pair.
`timescale 1ns/1ps
`default_nettype none
module deadtime_gen
(
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire pwm_in,
  input wire tick_in,
  input wire [3:0] true_nib_in,
  input wire [3:0] comp_nib_in,
  output reg true_out,
  output reg comp_out
);
  reg pwm_d;
  reg busy;
  reg [3:0] cnt;
  wire edge_seen;
  wire [3:0] load_val;

  assign edge_seen = pwm_in != pwm_d;
  // Rising edges delay the true output, falling edges the complementary one.
  assign load_val = pwm_in ? true_nib_in : comp_nib_in;

  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwm_d <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
      true_out <= 1'b0;
      comp_out <= 1'b0;
    end
    else
    begin
      pwm_d <= pwm_in;
      if (edge_seen)
      begin
        // A new edge restarts insertion, so a short pulse never overlaps the pair.
        if (load_val == 4'h0)
        begin
          busy <= 1'b0;
          true_out <= pwm_in;
          comp_out <= ~pwm_in;
        end
        else
        begin
          busy <= 1'b1;
          cnt <= load_val;
          true_out <= 1'b0;
          comp_out <= 1'b0;
        end
      end
      else if (busy && tick_in)
      begin
        if (cnt == 4'h1)
        begin
          busy <= 1'b0;
          true_out <= pwm_d;
          comp_out <= ~pwm_d;
        end
        cnt <= cnt - 4'h1;
      end
      else if (!busy)
      begin
        true_out <= pwm_d;
        comp_out <= ~pwm_d;
      end
    end
  end
endmodule
`default_nettype wire

// ==== timer_pwm_with_dead_time.v ====
// Eight-bit PWM timer with two dead-time pairs, PLL status bits and an AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_defines.vh"
// Notes on behaviour
// - PLL register bits 7 to 3 always read as zero.
// - Legacy mode forces fast clock enable and PLL enable set.
// - Lock detect at bit zero is set while the PLL is enabled and locked.
// - In PWM mode counter and duty compare form an 8-bit glitch-free PWM.
// - Counter counts up from zero to the top value, then restarts at zero.
// - Top match resets counter and sets overflow flag one cycle later.
// - Action 00 disconnects; 01 also, but drives high at duty top; 10 clears on match sets at one; 11 inverse.
// - Duty writes go to a holding register, latched when counter hits top, or every cycle while that channel's PWM bit is clear.
// - Duty reads return the holding register, the latest write.
// - Duty zero or top holds output static per action code.
// - Interrupt asks when flag, its enable and the global enable are set.
// - PWM period is top value plus one timer clock cycles.
// - Two independent dead-time generators make complementary pairs.
// - Dead-time prescaler divides by 1, 2, 4 or 8 from a 2-bit field.
// - The prescaler select field sits in the register at index 0x23.
// - PWM edge starts insertion; rising output waits for counter zero.
// - Counter loads high or low nibble depending on edge direction.
// - Bits 7:4 time the true output, bits 3:0 the complementary output.
// - Delay equals the nibble in prescaled clocks, zero to fifteen.
module timer_pwm_with_dead_time
(
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  input wire legacy_mode_in,
  input wire pll_locked_in,
  output reg pll_enable_out,
  output reg fast_clock_enable_out,
  output reg irq_out,
  output wire pwm_a_true_out,
  output wire pwm_a_comp_out,
  output wire pwm_b_true_out,
  output wire pwm_b_comp_out
);
  reg wr_pend;
  reg rd_pend;
  reg [7:0] acc_idx;
  reg acc_mapped;
  reg [7:0] control;
  reg [7:0] counter_value;
  reg [7:0] period_top_value;
  reg [7:0] duty_hold_a;
  reg [7:0] duty_hold_b;
  reg [7:0] duty_act_a;
  reg [7:0] duty_act_b;
  reg [7:0] flags;
  reg [7:0] int_en;
  reg [1:0] pll_ctrl;
  reg lock_detect;
  reg [1:0] deadtime_div_field;
  reg [7:0] deadtime_value_a;
  reg [7:0] deadtime_value_b;
  reg [1:0] pwm_raw;
  reg ovf_dly;
  reg cmp_a_dly;
  reg cmp_b_dly;
  reg [2:0] prescale_cnt;
  reg [7:0] rd_mux;
  reg [7:0] flag_clr;
  wire addr_phase;
  wire [7:0] wdata;
  wire cnt_write;
  wire top_hit;
  wire at_one;
  wire cmp_a_hit;
  wire cmp_b_hit;
  wire [1:0] pll_eff;
  wire dt_tick;
  wire [15:0] dt_cat;
  wire [1:0] true_w;
  wire [1:0] comp_w;
  wire [1:0] act_a;
  wire [1:0] act_b;

  function reg_wr;
    input pend;
    input [7:0] idx;
    input [7:0] target;
    begin
      reg_wr = pend && (idx == target);
    end
  endfunction

  // Next PWM level for one channel; static extremes win over edge events.
  function pwm_next;
    input [1:0] act;
    input [7:0] duty;
    input [7:0] top;
    input hit;
    input one;
    input cur;
    begin
      if (duty == 8'h00 && act != 2'b00)
        pwm_next = (act == 2'b11);
      else if (duty == top && act != 2'b00)
        pwm_next = (act != 2'b11);
      else if (act[1] == 1'b0)
        pwm_next = 1'b0;
      else if (hit)
        pwm_next = act[0];
      else if (one)
        pwm_next = ~act[0];
      else
        pwm_next = cur;
    end
  endfunction

  function [2:0] div_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: div_mask = 3'b000;
        2'b01: div_mask = 3'b001;
        2'b10: div_mask = 3'b011;
        default: div_mask = 3'b111;
      endcase
    end
  endfunction

  assign addr_phase = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ);
  assign wdata = hwdata_in[7:0];
  assign cnt_write = reg_wr(wr_pend, acc_idx, `IDX_COUNT);
  assign top_hit = (counter_value == period_top_value) && !cnt_write;
  assign at_one = (counter_value == `COUNT_ONE) && !cnt_write;
  // A counter write masks compare events in its own cycle; a loaded value equal to duty still matches on the next cycle.
  assign cmp_a_hit = (counter_value == duty_act_a) && !cnt_write;
  assign cmp_b_hit = (counter_value == duty_act_b) && !cnt_write;
  assign pll_eff = legacy_mode_in ? 2'b11 : pll_ctrl;
  assign dt_tick = (prescale_cnt & div_mask(deadtime_div_field)) ==
    div_mask(deadtime_div_field);
  assign dt_cat = {deadtime_value_b, deadtime_value_a};
  assign act_a = control[`CTRL_ACT_A_LO +: 2];
  assign act_b = control[`CTRL_ACT_B_LO +: 2];
  assign pwm_a_true_out = true_w[0];
  assign pwm_a_comp_out = comp_w[0];
  assign pwm_b_true_out = true_w[1];
  assign pwm_b_comp_out = comp_w[1];

  // Bus slave: writes land in the data phase, reads take one wait state so a
  // read right behind a write always sees the new value.
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_idx <= 8'h00;
      acc_mapped <= 1'b0;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
    else
    begin
      wr_pend <= 1'b0;
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        hreadyout_out <= 1'b1;
        hrdata_out <= {24'h000000, rd_mux};
      end
      else if (addr_phase)
      begin
        acc_idx <= haddr_in[9:2];
        acc_mapped <= (haddr_in[31:10] == 22'h000000) && (haddr_in[1:0] == 2'b00);
        wr_pend <= hwrite_in && (haddr_in[31:10] == 22'h000000);
        rd_pend <= !hwrite_in;
        hreadyout_out <= hwrite_in;
      end
    end
  end

  always @*
  begin
    rd_mux = 8'h00;
    if (acc_mapped)
    begin
      case (acc_idx)
        `IDX_DT_PRESCALE: rd_mux = {6'h00, deadtime_div_field};
        `IDX_DT_B: rd_mux = deadtime_value_b;
        `IDX_DT_A: rd_mux = deadtime_value_a;
        `IDX_PLL: rd_mux = {5'h00, pll_eff, lock_detect};
        `IDX_DUTY_B: rd_mux = duty_hold_b;
        `IDX_TOP: rd_mux = period_top_value;
        `IDX_DUTY_A: rd_mux = duty_hold_a;
        `IDX_COUNT: rd_mux = counter_value;
        `IDX_CONTROL: rd_mux = control;
        `IDX_FLAGS: rd_mux = flags;
        `IDX_INT_EN: rd_mux = int_en;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always @*
  begin
    flag_clr = 8'h00;
    if (reg_wr(wr_pend, acc_idx, `IDX_FLAGS))
      flag_clr = wdata & `FLAG_MASK;
  end

  // Software registers.
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      control <= 8'h00;
      period_top_value <= `TOP_RESET;
      duty_hold_a <= 8'h00;
      duty_hold_b <= 8'h00;
      int_en <= 8'h00;
      pll_ctrl <= 2'b00;
      deadtime_div_field <= 2'b00;
      deadtime_value_a <= 8'h00;
      deadtime_value_b <= 8'h00;
    end
    else
    begin
      if (reg_wr(wr_pend, acc_idx, `IDX_CONTROL))
        control <= wdata;
      if (reg_wr(wr_pend, acc_idx, `IDX_TOP))
        period_top_value <= wdata;
      if (reg_wr(wr_pend, acc_idx, `IDX_DUTY_A))
        duty_hold_a <= wdata;
      if (reg_wr(wr_pend, acc_idx, `IDX_DUTY_B))
        duty_hold_b <= wdata;
      if (reg_wr(wr_pend, acc_idx, `IDX_INT_EN))
        int_en <= wdata & (`FLAG_MASK | 8'h80);
      if (reg_wr(wr_pend, acc_idx, `IDX_PLL))
        pll_ctrl <= wdata[`PLL_FAST:`PLL_ENABLE];
      if (reg_wr(wr_pend, acc_idx, `IDX_DT_PRESCALE))
        deadtime_div_field <= wdata[1:0];
      if (reg_wr(wr_pend, acc_idx, `IDX_DT_A))
        deadtime_value_a <= wdata;
      if (reg_wr(wr_pend, acc_idx, `IDX_DT_B))
        deadtime_value_b <= wdata;
    end
  end

  // Counter, compare latching and PWM levels.
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      counter_value <= 8'h00;
      duty_act_a <= 8'h00;
      duty_act_b <= 8'h00;
      pwm_raw <= 2'b00;
      ovf_dly <= 1'b0;
      cmp_a_dly <= 1'b0;
      cmp_b_dly <= 1'b0;
    end
    else
    begin
      if (cnt_write)
        counter_value <= wdata;
      else if (top_hit)
        counter_value <= 8'h00;
      else
        counter_value <= counter_value + 8'h01;
      // In PWM mode, latching only at top keeps a mid-period write from cutting a pulse short.
      if (top_hit || !control[`CTRL_PWM_A])
        duty_act_a <= duty_hold_a;
      if (top_hit || !control[`CTRL_PWM_B])
        duty_act_b <= duty_hold_b;
      if (control[`CTRL_PWM_A])
        pwm_raw[0] <= pwm_next(act_a, duty_act_a, period_top_value, cmp_a_hit,
          at_one, pwm_raw[0]);
      else
        pwm_raw[0] <= 1'b0;
      if (control[`CTRL_PWM_B])
        pwm_raw[1] <= pwm_next(act_b, duty_act_b, period_top_value, cmp_b_hit,
          at_one, pwm_raw[1]);
      else
        pwm_raw[1] <= 1'b0;
      ovf_dly <= top_hit;
      cmp_a_dly <= cmp_a_hit;
      cmp_b_dly <= cmp_b_hit;
    end
  end

  // Flags are write-one-to-clear; a set arriving with the clear wins.
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags <= 8'h00;
      irq_out <= 1'b0;
    end
    else
    begin
      flags[`FLAG_OVF] <= ovf_dly | (flags[`FLAG_OVF] & ~flag_clr[`FLAG_OVF]);
      flags[`FLAG_CMP_A] <= cmp_a_dly | (flags[`FLAG_CMP_A] & ~flag_clr[`FLAG_CMP_A]);
      flags[`FLAG_CMP_B] <= cmp_b_dly | (flags[`FLAG_CMP_B] & ~flag_clr[`FLAG_CMP_B]);
      irq_out <= int_en[`INT_GLOBAL] && ((flags & int_en & `FLAG_MASK) != 8'h00);
    end
  end

  // PLL status; the lock input only counts while the loop is enabled.
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lock_detect <= 1'b0;
      pll_enable_out <= 1'b0;
      fast_clock_enable_out <= 1'b0;
    end
    else
    begin
      lock_detect <= pll_locked_in && pll_eff[0];
      pll_enable_out <= pll_eff[0];
      fast_clock_enable_out <= pll_eff[1];
    end
  end

  // Free-running dead-time prescaler shared by both generators.
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      prescale_cnt <= 3'b000;
    else
      prescale_cnt <= prescale_cnt + 3'b001;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_dt
      deadtime_gen u_dt
      (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pwm_in(pwm_raw[gi]),
        .tick_in(dt_tick),
        .true_nib_in(dt_cat[gi*8+4 +: 4]),
        .comp_nib_in(dt_cat[gi*8 +: 4]),
        .true_out(true_w[gi]),
        .comp_out(comp_w[gi])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ==== timer_pwm_assertions.sv ====
// Concurrent checks on the ports of the PWM timer with dead time.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_defines.vh"
module timer_pwm_checker
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic legacy_mode_in,
  input wire logic pll_enable_out,
  input wire logic fast_clock_enable_out,
  input wire logic pwm_a_true_out,
  input wire logic pwm_a_comp_out,
  input wire logic pwm_b_true_out,
  input wire logic pwm_b_comp_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic go = hsel_in && hready_in && htrans_in == `HTRANS_NONSEQ;
  pair_a_apart_a: assert property (!(pwm_a_true_out && pwm_a_comp_out))
    else $error("pair a overlap");
  pair_b_apart_a: assert property (!(pwm_b_true_out && pwm_b_comp_out))
    else $error("pair b overlap");
  legacy_forces_a: assert property (legacy_mode_in |=> pll_enable_out && fast_clock_enable_out)
    else $error("legacy mode not forcing enables");
  read_wait_a: assert property (go && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  write_ready_a: assert property (go && hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  resp_okay_a: assert property (hresp_out == 1'b0)
    else $error("error response");
  pll_reserved_a: assert property (go && !hwrite_in && haddr_in[9:2] == `IDX_PLL |=> ##1 hrdata_out[7:3] == 5'h0)
    else $error("reserved pll bits set");
  upper_zero_a: assert property (go && !hwrite_in |=> ##1 hrdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind timer_pwm_with_dead_time timer_pwm_checker chk_i (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .legacy_mode_in(legacy_mode_in),
  .pll_enable_out(pll_enable_out), .fast_clock_enable_out(fast_clock_enable_out),
  .pwm_a_true_out(pwm_a_true_out), .pwm_a_comp_out(pwm_a_comp_out),
  .pwm_b_true_out(pwm_b_true_out), .pwm_b_comp_out(pwm_b_comp_out));
`default_nettype wire

// ==== power_stage_model.sv ====
// Behavioural model of the two switch legs driven by the output pairs.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
(
  input wire logic clk_in,
  input wire logic a_high_in,
  input wire logic a_low_in,
  input wire logic b_high_in,
  input wire logic b_low_in,
  output logic [7:0] shoot_cnt_out
);
  // Both switches of a leg on together short the supply, so each such cycle is counted.
  initial shoot_cnt_out = 8'h0;
  always @(posedge clk_in)
  begin
    if ((a_high_in && a_low_in) || (b_high_in && b_low_in))
      shoot_cnt_out <= shoot_cnt_out + 8'h1;
  end
endmodule
`default_nettype wire

// ==== timer_pwm_with_dead_time_tb.sv ====
// Self-checking testbench for the PWM timer with dead time.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_defines.vh"
module timer_pwm_with_dead_time_tb;
  logic clk, rst_n, hsel, hwrite, legacy, locked;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  wire logic [31:0] hrdata;
  wire logic [7:0] shoot;
  wire logic hready, hresp, pll_en, fast_en, irq, at, ac, bt, bc;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  timer_pwm_with_dead_time DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .legacy_mode_in(legacy), .pll_locked_in(locked),
    .pll_enable_out(pll_en), .fast_clock_enable_out(fast_en), .irq_out(irq),
    .pwm_a_true_out(at), .pwm_a_comp_out(ac), .pwm_b_true_out(bt), .pwm_b_comp_out(bc));
  power_stage_model load (.clk_in(clk), .a_high_in(at), .a_low_in(ac), .b_high_in(bt),
    .b_low_in(bc), .shoot_cnt_out(shoot));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // The master holds each phase until hready is seen high at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= `HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h0, r);
    chk(r, {24'h0, e});
  endtask
  function automatic logic pin(input logic [1:0] s);
    return s == 2'h0 ? at : s == 2'h1 ? ac : bt;
  endfunction
  task automatic meas(input logic [1:0] s, output int hi, output int pd);
    hi = 0;
    while (pin(s) !== 1'b0) @(posedge clk);
    while (pin(s) !== 1'b1) @(posedge clk);
    while (pin(s) === 1'b1)
    begin
      hi++;
      @(posedge clk);
    end
    pd = hi;
    while (pin(s) !== 1'b1)
    begin
      pd++;
      @(posedge clk);
    end
  endtask
  // Dead time is seen from the fall of one output to the rise of the other.
  task automatic gap(input logic [1:0] s, input int lim, input int div);
    int g;
    g = 0;
    while (pin(~s & 2'h1) !== 1'b1) @(posedge clk);
    while (pin(~s & 2'h1) === 1'b1) @(posedge clk);
    while (pin(s) !== 1'b1)
    begin
      chk(pin(~s & 2'h1), 1'b0);
      g++;
      @(posedge clk);
    end
    chk(g > lim - div && g <= lim + 1, 1'b1);
  endtask
  task automatic t_regs;
    rdc(`IDX_TOP, `TOP_RESET);
    rdc(`IDX_PLL, 8'h00);
    wr(`IDX_PLL, 8'hff);
    rdc(`IDX_PLL, 8'h06);
    locked <= 1'b1;
    rdc(`IDX_PLL, 8'h07);
    wr(`IDX_PLL, 8'h00);
    legacy <= 1'b1;
    rdc(`IDX_PLL, 8'h07);
    chk({pll_en, fast_en}, 2'h3);
    legacy <= 1'b0;
    wr(`IDX_DT_PRESCALE, 8'hff);
    rdc(`IDX_DT_PRESCALE, 8'h03);
    rdc(8'h00, 8'h00);
  endtask
  task automatic t_pwm;
    int hi, pd;
    logic [7:0] ctl [6] = '{8'h21, 8'h21, 8'h31, 8'h31, 8'h11, 8'h01};
    logic [7:0] dty [6] = '{8'h00, 8'h09, 8'h00, 8'h09, 8'h09, 8'h09};
    logic lvl [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(`IDX_TOP, 8'h09);
    wr(`IDX_DUTY_A, 8'h03);
    wr(`IDX_CONTROL, 8'h21);
    meas(2'h0, hi, pd);
    chk(pd, 10);
    chk(hi, 2);
    wr(`IDX_CONTROL, 8'h31);
    // A pulse begun under the old action code may still be running; let it pass.
    repeat (12) @(posedge clk);
    meas(2'h0, hi, pd);
    chk(hi, 8);
    wr(`IDX_CONTROL, 8'h21);
    wr(`IDX_DUTY_A, 8'h06);
    rdc(`IDX_DUTY_A, 8'h06);
    meas(2'h0, hi, pd);
    meas(2'h0, hi, pd);
    chk(hi, 5);
    for (int i = 0; i < 6; i++)
    begin
      wr(`IDX_CONTROL, ctl[i]);
      wr(`IDX_DUTY_A, dty[i]);
      repeat (24) @(posedge clk);
      repeat (12)
      begin
        @(posedge clk);
        chk(at, lvl[i]);
      end
    end
  endtask
  task automatic t_irq;
    wr(`IDX_INT_EN, 8'h84);
    wr(`IDX_FLAGS, 8'h64);
    repeat (14) @(posedge clk);
    chk(irq, 1'b1);
    // Both compare values lie inside the count range, so their flags set too.
    rdc(`IDX_FLAGS, 8'h64);
    wr(`IDX_INT_EN, 8'h04);
    wr(`IDX_FLAGS, 8'h64);
    repeat (14) @(posedge clk);
    chk(irq, 1'b0);
  endtask
  task automatic t_dead;
    int hi, pd;
    wr(`IDX_TOP, 8'hff);
    wr(`IDX_DUTY_A, 8'h80);
    wr(`IDX_CONTROL, 8'h21);
    wr(`IDX_DT_A, 8'h36);
    for (int i = 0; i < 4; i++)
    begin
      wr(`IDX_DT_PRESCALE, i[7:0]);
      gap(2'h0, 3 << i, 1 << i);
      gap(2'h1, 6 << i, 1 << i);
    end
    wr(`IDX_DUTY_B, 8'h40);
    wr(`IDX_CONTROL, 8'h0a);
    meas(2'h2, hi, pd);
    chk(pd, 256);
    chk(hi, 63);
    chk(bc, !bt);
    chk(at, 1'b0);
  endtask
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    legacy = 1'b0;
    locked = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pwm();
    t_irq();
    t_dead();
    chk(shoot, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
